// ==== dma_crc_defs.svh ====
// Purpose: register offsets, field positions and reset values of the dma
//          global, crc and per-channel register block
// Assumes: byte addresses on a 32-bit word register port
// Notes:   per-channel registers sit in a window of their own per channel
`ifndef DMA_CRC_DEFS_SVH
`define DMA_CRC_DEFS_SVH

`define OFS_GLOBAL_CONTROL 16'h3000
`define OFS_GLOBAL_STATUS 16'h3010
`define OFS_ERROR_ADDRESS 16'h3020
`define OFS_CRC_CONTROL 16'h3030
`define OFS_CRC_DATA_SEED 16'h3040
`define OFS_CRC_POLY_XOR 16'h3050
`define OFS_IRQ_STATUS 16'h3070
`define OFS_IRQ_MASK 16'h3080
`define OFS_CHAN_BASE 16'h3100
`define CHAN_STRIDE 16'h0100
`define OFS_CH_INT 8'h30
`define OFS_CH_SRC 8'h40
`define OFS_CH_DST 8'h50
`define ALIAS_CLR 2'h1
`define ALIAS_SET 2'h2
`define ALIAS_INV 2'h3

`define CTRL_ON_BIT 15
`define CTRL_SUSPEND_BIT 12
`define CTRL_BUSY_BIT 11
`define CTRL_WMASK 32'h0000_9000
`define CRC_WBO_BIT 27
`define CRC_EN_BIT 7
`define CRC_APP_BIT 6
`define CRC_TYP_BIT 5
`define CRC_CH_LSB 0
`define CRC_WMASK 32'h3900_1fe7
`define STAT_WR_BIT 3
`define FLAG_DHIF 4
`define FLAG_BCIF 3
`define FLAG_CCIF 2
`define FLAG_TAIF 1
`define FLAG_ERIF 0
`define RESET_WORD 32'h0000_0000

`endif

// ==== dma_crc_pkg.sv ====
// Purpose: types shared by the dma crc register block
// Assumes: nothing beyond the defs header
// Notes:   states are one-hot
package dma_crc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MOVE = 4'b0010,
    ST_APPEND = 4'b0100,
    ST_DONE = 4'b1000
  } xfer_state_e;
  typedef logic [31:0] word_t;
endpackage

// ==== dma_crc_channel_flags.sv ====
// Purpose: global control/status, crc engine, per-channel start addresses
//          and interrupt flags of a multi-channel dma controller
// Assumes: one clock, async active-high reset, plain register port with
//          read data one cycle after the read strobe
// Notes:   the data mover itself is abstracted to a per-channel word stream
//
// Function
// - global and crc registers have clear, set, invert aliases at +4, +8, +c
// - append mode feeds crc only; crc written to destination at block end
// - normal mode passes data through crc and destination, obeying byte order
// - crc type one gives ip header checksum, zero gives lfsr crc
// - three-bit channel select attaches crc engine to exactly one channel
// - with byte order set, no unaligned transfers and append cannot be set
// - destination half-full flag sets when pointer reaches half the size
// - block complete flag sets at larger size transferred or pattern match
// - cell complete flag sets each time cell-size bytes are transferred
// - matching abort request aborts the transfer and sets abort flag
// - address error flag sets on invalid source or destination address
// - flags read zero with nothing pending and are zero after reset
`include "dma_crc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dma_crc_channel_flags
  import dma_crc_pkg::*;
#(
  parameter int NCH = 8
) (
  input wire logic clock,                  // 200 mhz system clock
  input wire logic sys_rst,                // async reset, active high
  input wire logic [15:0] reg_addr,        // register byte address
  input wire logic [31:0] reg_wdata,       // register write data
  input wire logic reg_wr,                 // write strobe
  input wire logic reg_rd,                 // read strobe
  output logic [31:0] reg_rdata,           // read data, cycle after strobe
  input wire logic [NCH-1:0] ch_start,     // pulse: start channel block
  input wire logic [NCH-1:0] ch_beat,      // pulse: one source word moved
  input wire logic [31:0] src_word,        // source word of the beat
  input wire logic [NCH-1:0] ch_dst_half,  // pointer reached half size
  input wire logic [NCH-1:0] ch_cell_done, // cell size bytes moved
  input wire logic [NCH-1:0] ch_blk_done,  // larger of sizes moved
  input wire logic [NCH-1:0] ch_pat_match, // pattern match event
  input wire logic [NCH-1:0] ch_abort_irq, // abort irq number matched
  input wire logic [NCH-1:0] ch_addr_err,  // invalid src or dst address
  input wire logic [31:0] err_addr,        // offending address
  output logic [NCH-1:0] ch_abort,         // pulse: abort the channel
  output logic dst_wr,                     // destination write strobe
  output logic [31:0] dst_addr,            // destination write address
  output logic [31:0] dst_data,            // destination write data
  output logic irq                         // level interrupt
);

  localparam int CW = $clog2(NCH);

  word_t ctrl_r, crc_ctrl_r, seed_r, poly_r, err_addr_r;
  logic [4:0] status_r;
  logic [NCH-1:0] irq_stat_r, irq_mask_r;
  logic [4:0] flags_r [NCH];
  logic [15:0] flag_en_r [NCH];
  word_t src_r [NCH];
  word_t dst_r [NCH];
  word_t crc_r;
  xfer_state_e st_r;
  logic [CW-1:0] crc_ch;
  logic busy;

  // alias decode: low nibble of address picks plain, clear, set or invert
  logic [15:0] base;
  logic [1:0] alias_sel;
  assign base = {reg_addr[15:4], 4'h0};
  assign alias_sel = reg_addr[3:2];

  function automatic word_t apply_alias(input word_t cur, input word_t wd,
                                        input logic [1:0] sel);
    case (sel)
      `ALIAS_CLR: apply_alias = cur & ~wd;
      `ALIAS_SET: apply_alias = cur | wd;
      `ALIAS_INV: apply_alias = cur ^ wd;
      default: apply_alias = wd;
    endcase
  endfunction

  // ip checksum: ones-complement sum of two halfwords folded in
  function automatic word_t csum_step(input word_t acc, input word_t d);
    logic [17:0] s;
    s = {2'b00, acc[15:0]} + {2'b00, d[31:16]} + {2'b00, d[15:0]};
    s = {2'b00, s[15:0]} + {16'h0000, s[17:16]};
    csum_step = {16'h0000, s[15:0] + {15'h0000, s[16]}};
  endfunction

  // lfsr crc: one bit per shift, polynomial taken from the xor register
  function automatic word_t lfsr_step(input word_t acc, input word_t d,
                                      input word_t poly);
    word_t c;
    c = acc;
    for (int i = 31; i >= 0; i--) begin
      c = (c[31] ^ d[i]) ? ((c << 1) ^ poly) : (c << 1);
    end
    lfsr_step = c;
  endfunction

  assign crc_ch = crc_ctrl_r[`CRC_CH_LSB +: CW];
  assign busy = (st_r != ST_IDLE);

  logic w_ctrl, w_crc, w_seed, w_poly;
  assign w_ctrl = reg_wr && base == `OFS_GLOBAL_CONTROL;
  assign w_crc = reg_wr && base == `OFS_CRC_CONTROL;
  assign w_seed = reg_wr && base == `OFS_CRC_DATA_SEED;
  assign w_poly = reg_wr && base == `OFS_CRC_POLY_XOR;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= `RESET_WORD;
    end else if (w_ctrl) begin
      ctrl_r <= apply_alias(ctrl_r, reg_wdata, alias_sel)
                & `CTRL_WMASK;
    end
  end

  // byte order set forbids append; a write setting both keeps append clear
  always_ff @(posedge clock or posedge sys_rst) begin
    word_t nv;
    if (sys_rst) begin
      crc_ctrl_r <= `RESET_WORD;
    end else if (w_crc) begin
      nv = apply_alias(crc_ctrl_r, reg_wdata, alias_sel) & `CRC_WMASK;
      if (nv[`CRC_WBO_BIT]) begin
        nv[`CRC_APP_BIT] = 1'b0;
      end
      crc_ctrl_r <= nv;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      poly_r <= `RESET_WORD;
    end else if (w_poly) begin
      poly_r <= apply_alias(poly_r, reg_wdata, alias_sel);
    end
  end

  // seed register reads back the running crc once the engine has started
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      seed_r <= `RESET_WORD;
    end else if (w_seed) begin
      seed_r <= apply_alias(crc_r, reg_wdata, alias_sel);
    end
  end

  // crc engine and transfer sequencer of the attached channel
  logic eng_beat, eng_start, eng_end, app;
  assign eng_beat = ch_beat[crc_ch] && crc_ctrl_r[`CRC_EN_BIT];
  assign eng_start = ch_start[crc_ch] && crc_ctrl_r[`CRC_EN_BIT];
  assign eng_end = ch_blk_done[crc_ch] || ch_abort_irq[crc_ch];
  assign app = crc_ctrl_r[`CRC_APP_BIT];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      crc_r <= `RESET_WORD;
    end else begin
      if (w_seed) begin
        crc_r <= apply_alias(crc_r, reg_wdata, alias_sel);
      end else if (eng_start && st_r == ST_IDLE) begin
        crc_r <= seed_r; // each block restarts from the programmed seed
      end else if (eng_beat && st_r == ST_MOVE) begin
        crc_r <= crc_ctrl_r[`CRC_TYP_BIT] ? csum_step(crc_r, src_word)
                 : lfsr_step(crc_r, src_word, poly_r);
      end
      case (st_r)
        ST_IDLE: if (eng_start) begin
          st_r <= ST_MOVE;
        end
        ST_MOVE: if (ch_abort_irq[crc_ch]) begin
          st_r <= ST_IDLE;
        end else if (eng_end) begin
          st_r <= app ? ST_APPEND : ST_DONE;
        end
        ST_APPEND: st_r <= ST_DONE;
        ST_DONE: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // destination writes: data path in normal mode, crc value in append mode
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dst_wr <= 1'b0;
      dst_addr <= `RESET_WORD;
      dst_data <= `RESET_WORD;
    end else begin
      dst_wr <= 1'b0;
      if (st_r == ST_APPEND) begin
        dst_wr <= 1'b1;
        dst_addr <= dst_r[crc_ch];
        dst_data <= crc_r;
      end else if (eng_beat && st_r == ST_MOVE && !app) begin
        dst_wr <= 1'b1;
        dst_addr <= dst_r[crc_ch];
        dst_data <= crc_ctrl_r[`CRC_WBO_BIT] ?
                    {src_word[7:0], src_word[15:8],
                     src_word[23:16], src_word[31:24]} : src_word;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ch_abort <= '0;
    end else begin
      ch_abort <= ch_abort_irq;
    end
  end

  // global status: channel of the last address error, no direction bit, error address
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= 5'h00;
      err_addr_r <= `RESET_WORD;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (ch_addr_err[c]) begin
          status_r <= {1'b0, 4'(c)};
          err_addr_r <= err_addr;
        end
      end
    end
  end

  // per-channel registers
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [15:0] cb;
      logic hit;
      logic [4:0] ev;
      assign cb = 16'(`OFS_CHAN_BASE + g * `CHAN_STRIDE);
      assign hit = reg_wr && reg_addr[15:8] == cb[15:8];
      assign ev = {ch_dst_half[g],
                   ch_blk_done[g] | ch_pat_match[g],
                   ch_cell_done[g],
                   ch_abort_irq[g],
                   ch_addr_err[g]};

      always_ff @(posedge clock or posedge sys_rst) begin
        word_t nv;
        if (sys_rst) begin
          flags_r[g] <= 5'h00;
          flag_en_r[g] <= 16'h0000;
        end else begin
          nv = {flag_en_r[g], 11'h000, flags_r[g]};
          if (hit && reg_addr[7:4] == `OFS_CH_INT >> 4) begin
            nv = apply_alias(nv, reg_wdata, alias_sel);
          end
          flags_r[g] <= nv[4:0] | ev;
          flag_en_r[g] <= nv[31:16];
        end
      end

      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          src_r[g] <= `RESET_WORD;
          dst_r[g] <= `RESET_WORD;
        end else if (hit && !busy) begin
          if (reg_addr[7:4] == `OFS_CH_SRC >> 4) begin
            src_r[g] <= apply_alias(src_r[g], reg_wdata, alias_sel);
          end
          if (reg_addr[7:4] == `OFS_CH_DST >> 4) begin
            dst_r[g] <= apply_alias(dst_r[g], reg_wdata, alias_sel);
          end
        end
      end
    end
  endgenerate

  // sticky channel interrupt summary; a read clears, a new event wins
  logic [NCH-1:0] ch_any;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ch_any[c] = |(flags_r[c] & flag_en_r[c][4:0]);
    end
  end

  logic rd_stat;
  assign rd_stat = reg_rd && reg_addr == `OFS_IRQ_STATUS;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (rd_stat ? '0 : irq_stat_r) | ch_any;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_r <= '0;
    end else if (reg_wr && reg_addr == `OFS_IRQ_MASK) begin
      irq_mask_r <= reg_wdata[NCH-1:0];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((rd_stat ? '0 : irq_stat_r) & irq_mask_r);
    end
  end

  // read mux; aliases read as the base register, unmapped reads zero
  always_ff @(posedge clock or posedge sys_rst) begin
    logic [CW-1:0] ci;
    if (sys_rst) begin
      reg_rdata <= `RESET_WORD;
    end else begin
      ci = CW'(reg_addr[15:8] - 8'h31);
      reg_rdata <= `RESET_WORD;
      if (reg_rd) begin
        case (base)
          `OFS_GLOBAL_CONTROL:
            reg_rdata <= ctrl_r | (32'(busy) << `CTRL_BUSY_BIT);
          `OFS_GLOBAL_STATUS: reg_rdata <= {27'h0, status_r};
          `OFS_ERROR_ADDRESS: reg_rdata <= err_addr_r;
          `OFS_CRC_CONTROL: reg_rdata <= crc_ctrl_r;
          `OFS_CRC_DATA_SEED: reg_rdata <= crc_r;
          `OFS_CRC_POLY_XOR: reg_rdata <= poly_r;
          `OFS_IRQ_STATUS: reg_rdata <= 32'(irq_stat_r);
          `OFS_IRQ_MASK: reg_rdata <= 32'(irq_mask_r);
          default: begin
            if (reg_addr[15:8] >= 8'h31 && reg_addr[15:8] < 8'(8'h31 + NCH)) begin
              case (reg_addr[7:4])
                4'h3: reg_rdata <= {flag_en_r[ci], 11'h000, flags_r[ci]};
                4'h4: reg_rdata <= src_r[ci];
                4'h5: reg_rdata <= dst_r[ci];
                default: reg_rdata <= `RESET_WORD;
              endcase
            end
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== dma_crc_chk.sv ====
// Purpose: port checks of the dma crc register block
// Assumes: sees top module ports only
// Notes: bound to the design below the module
`timescale 1ns/1ps
`default_nettype none
module dma_crc_chk #(
  parameter int NCH = 8
) (
  input wire logic clock, // clock
  input wire logic sys_rst, // reset
  input wire logic [15:0] reg_addr, // address
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic [NCH-1:0] ch_beat, // beats
  input wire logic [NCH-1:0] ch_dst_half, // event
  input wire logic [NCH-1:0] ch_cell_done, // event
  input wire logic [NCH-1:0] ch_blk_done, // event
  input wire logic [NCH-1:0] ch_pat_match, // event
  input wire logic [NCH-1:0] ch_abort_irq, // event
  input wire logic [NCH-1:0] ch_addr_err, // event
  input wire logic [NCH-1:0] ch_abort, // abort out
  input wire logic dst_wr, // dest write
  input wire logic irq // interrupt
);
  logic ev_any;
  logic blk_any;
  assign blk_any = |{ch_blk_done, ch_pat_match};
  assign ev_any = |{ch_dst_half, ch_cell_done, ch_abort_irq, ch_addr_err}
    | blk_any | reg_wr;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_abort_follows: assert property (
    ch_abort_irq != '0 |=>
    (ch_abort & $past(ch_abort_irq)) == $past(ch_abort_irq))
    else $error("abort pulse missing");
  a_abort_cause: assert property (
    ch_abort != '0 |-> (ch_abort & ~$past(ch_abort_irq)) == '0)
    else $error("abort without request");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == '0) else $error("read data not idle");
  a_quiet_reset: assert property (
    $past(sys_rst) |-> !irq && !dst_wr && ch_abort == '0)
    else $error("output set after reset");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(ev_any) || $past(ev_any, 2) || $past(ev_any, 3))
    else $error("irq without event");
  a_dst_cause: assert property (
    dst_wr |-> $past(ch_beat != '0) || $past(blk_any, 2)
    || $past(blk_any, 3) || $past(blk_any)) else $error("stray dest write");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 16'h3060 |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_wbo_no_app: assert property (
    reg_rd && reg_addr == 16'h3030 |=> !(reg_rdata[27] && reg_rdata[6]))
    else $error("append set with byte order");
  a_crc_gap: assert property (
    reg_rd && reg_addr == 16'h3030 |=> reg_rdata[4:3] == 2'h0)
    else $error("crc control gap bits set");
endmodule
bind dma_crc_channel_flags dma_crc_chk #(.NCH(NCH)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch_beat(ch_beat),
  .ch_dst_half(ch_dst_half), .ch_cell_done(ch_cell_done),
  .ch_blk_done(ch_blk_done), .ch_pat_match(ch_pat_match),
  .ch_abort_irq(ch_abort_irq), .ch_addr_err(ch_addr_err),
  .ch_abort(ch_abort), .dst_wr(dst_wr), .irq(irq));
`default_nettype wire

// ==== sys_mem_model.sv ====
// Purpose: destination memory seen by the engine
// Assumes: takes a write in the cycle it is offered
// Notes: keeps only the latest write and a count
`timescale 1ns/1ps
`default_nettype none
module sys_mem_model (
  input wire logic clock, // clock
  input wire logic sys_rst, // reset
  input wire logic dst_wr, // write strobe
  input wire logic [31:0] dst_addr, // physical address
  input wire logic [31:0] dst_data, // write data
  output logic [15:0] wr_count, // writes taken
  output logic [31:0] last_addr, // latest address
  output logic [31:0] last_data // latest data
);
  // never stalls, so slow-bus cases are out of reach here
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_count <= 16'h0;
      last_addr <= 32'h0;
      last_data <= 32'h0;
    end else if (dst_wr) begin
      wr_count <= wr_count + 16'h1;
      last_addr <= dst_addr;
      last_data <= dst_data;
    end
  end
endmodule
`default_nettype wire

// ==== dma_crc_channel_flags_tb.sv ====
// Purpose: self-checking bench of the dma crc register block
// Assumes: memory model on the destination side, checker bound
// Notes: crc results are compared between crc types, and the checksum against a fixed value
`timescale 1ns/1ps
`default_nettype none
module dma_crc_channel_flags_tb import dma_crc_pkg::*;;
  typedef struct {logic [15:0] a; word_t w; logic [15:0] ra; word_t e;} row_s;
  logic clock, sys_rst, reg_wr, reg_rd, i0;
  logic [15:0] reg_addr;
  word_t reg_wdata, src_word, err_addr, d, c0;
  logic [7:0] ch_start, ch_beat;
  logic [7:0] ev [6];
  wire logic [31:0] reg_rdata, dst_addr, dst_data, last_addr, last_data;
  wire logic [7:0] ch_abort;
  wire logic dst_wr, irq;
  wire logic [15:0] wr_count;
  int n_fail, cmp_count;
  int fb [6] = '{4, 3, 2, 1, 0, 3};
  logic [15:0] ra [6] = '{16'h3000, 16'h3010, 16'h3020, 16'h3030,
    16'h3140, 16'h3230};
  row_s rows [13] = '{
    '{16'h3040, 32'h12345678, 16'h3040, 32'h12345678},
    '{16'h3140, 32'h10000000, 16'h3140, 32'h10000000},
    '{16'h3750, 32'h20000004, 16'h3750, 32'h20000004},
    '{16'h3000, 32'hffffffff, 16'h3000, 32'h00009000},
    '{16'h3004, 32'hffffffff, 16'h3000, 32'h0},
    '{16'h3060, 32'hffffffff, 16'h3060, 32'h0},
    '{16'h3030, 32'hffffffff, 16'h3030, 32'h39001fa7},
    '{16'h3030, 32'h00000007, 16'h3030, 32'h7},
    '{16'h3034, 32'h00000003, 16'h3030, 32'h4},
    '{16'h3038, 32'h00000060, 16'h3030, 32'h64},
    '{16'h303c, 32'h00000005, 16'h3030, 32'h61},
    '{16'h3038, 32'h08000000, 16'h3030, 32'h08000021},
    '{16'h3034, 32'hffffffff, 16'h3030, 32'h0}};
  dma_crc_channel_flags #(.NCH(8)) u_dma_crc_channel_flags (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ch_start(ch_start), .ch_beat(ch_beat),
    .src_word(src_word), .ch_dst_half(ev[0]), .ch_blk_done(ev[1]),
    .ch_cell_done(ev[2]), .ch_abort_irq(ev[3]), .ch_addr_err(ev[4]),
    .ch_pat_match(ev[5]), .err_addr(err_addr), .ch_abort(ch_abort),
    .dst_wr(dst_wr), .dst_addr(dst_addr), .dst_data(dst_data), .irq(irq));
  sys_mem_model u_sys_mem_model (.clock(clock), .sys_rst(sys_rst),
    .dst_wr(dst_wr), .dst_addr(dst_addr), .dst_data(dst_data),
    .wr_count(wr_count), .last_addr(last_addr), .last_data(last_data));
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input word_t g, input word_t e);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input word_t w);
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] a, output word_t r);
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 r = reg_rdata;
  endtask
  task automatic pulse(input int k, input int c);
    @(posedge clock);
    ev[k][c] <= 1'h1;
    @(posedge clock);
    ev[k][c] <= 1'h0;
  endtask
  task automatic beat(input int c, input word_t w);
    @(posedge clock);
    ch_beat[c] <= 1'h1;
    ch_start[c] <= 1'h0;
    src_word <= w;
    @(posedge clock);
    ch_beat[c] <= 1'h0;
  endtask
  task automatic app_run(output word_t r);
    logic [15:0] n;
    n = wr_count;
    @(posedge clock);
    ch_start[3] <= 1'h1;
    beat(3, 32'h4500003c);
    beat(3, 32'h1c468000);
    chk({16'h0, wr_count}, {16'h0, n});
    pulse(1, 3);
    repeat (4) @(posedge clock);
    chk({16'h0, wr_count}, {16'h0, n + 16'h1});
    chk(last_addr, 32'h20000100);
    r = last_data;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    stop_test();
  end
  initial begin
    sys_rst = 1'h1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, ch_start, ch_beat} = '0;
    src_word = 32'h0;
    err_addr = 32'h0bad0040;
    foreach (ev[k]) ev[k] = 8'h0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'h0;
    foreach (ra[k]) begin
      rd(ra[k], d);
      chk(d, 32'h0);
    end
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].w);
      rd(rows[k].ra, d);
      chk(d, rows[k].e);
    end
    foreach (fb[k]) begin
      pulse(k, 2);
      repeat (3) @(posedge clock);
      rd(16'h3330, d);
      chk(d & 32'h1f, 32'h1 << fb[k]);
      wr(16'h3334, 32'h1f);
      rd(16'h3330, d);
      chk(d & 32'h1f, 32'h0);
    end
    rd(16'h3020, d);
    chk(d, 32'h0bad0040);
    rd(16'h3010, d);
    chk(d, 32'h2);
    rd(16'h3070, d);
    wr(16'h3338, 32'h00040000);
    wr(16'h3080, 32'h04);
    pulse(2, 2);
    repeat (4) @(posedge clock);
    i0 = irq;
    wr(16'h3080, 32'h0);
    repeat (3) @(posedge clock);
    chk({31'h0, i0 ^ irq}, 32'h1);
    chk({31'h0, i0}, 32'h1);
    rd(16'h3070, d);
    chk(d & 32'hff, 32'h04);
    wr(16'h3334, 32'h4);
    rd(16'h3070, d);
    rd(16'h3070, d);
    repeat (3) @(posedge clock);
    chk({d[7:0] & 8'hff, 23'h0, irq}, 32'h0);
    // engine on channel 3 in normal mode: data passes to the destination
    wr(16'h3450, 32'h20000000);
    wr(16'h3030, 32'h00000083);
    @(posedge clock);
    ch_start[3] <= 1'h1;
    beat(3, 32'h11223344);
    repeat (2) @(posedge clock);
    chk(last_data, 32'h11223344);
    chk(last_addr, 32'h20000000);
    c0 = {16'h0, wr_count};
    beat(5, 32'h55667788);
    repeat (2) @(posedge clock);
    chk({16'h0, wr_count}, c0);
    wr(16'h3038, 32'h08000000);
    beat(3, 32'h11223344);
    repeat (2) @(posedge clock);
    chk(last_data, 32'h44332211);
    pulse(1, 3);
    repeat (4) @(posedge clock);
    wr(16'h3450, 32'h20000100);
    wr(16'h3040, 32'h0);
    wr(16'h3030, 32'h000000c3);
    app_run(c0);
    wr(16'h3040, 32'h0);
    wr(16'h3038, 32'h20);
    app_run(d);
    chk({31'h0, c0 !== d}, 32'h1);
    chk(d, 32'h0000e182);
    sys_rst <= 1'h1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'h0;
    rd(16'h3430, d);
    chk(d, 32'h0);
    rd(16'h3450, d);
    chk(d, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
